// >>> logic/rtarr_top.sv
// six independent 16-bit reload timers behind an apb slave
//
// The placing of the registers and the APB register port were decided locally.
module rtarr_top
  import rtarr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [rtarr_pkg::AW-1:0] paddr,
  input  wire logic [rtarr_pkg::DW-1:0] pwdata,
  output logic [rtarr_pkg::DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rtc_osc_output,
  input  wire logic              event_pin_a,
  input  wire logic              event_pin_b,
  output logic [rtarr_pkg::NTMR-1:0] timer_irq,
  output logic                   toggle_out_pin_a,
  output logic                   toggle_out_pin_a_oe,
  output logic                   toggle_out_pin_b,
  output logic                   toggle_out_pin_b_oe
);
  import rtarr_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // index of one register of one timer
  function automatic logic [9:0] tmr_idx(input int t, input logic [9:0] sub);
    tmr_idx = IDX_TMR_BASE + 10'(t * IDX_STRIDE) + sub;
  endfunction

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  logic [9:0]  widx;
  logic        aligned;
  logic        acc_go;
  logic        rd_go;
  logic        wr_go;
  logic        hit_src;
  logic        hit_out;
  logic        mapped;
  logic [7:0]  wbyte;
  logic [31:0] rd_mux;

  // word index, first access cycle, completing write
  assign widx    = paddr[AW-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign acc_go  = psel & penable & ~pready;
  assign rd_go   = acc_go & ~pwrite;
  assign wr_go   = psel & penable & pready & pwrite & aligned;
  assign wbyte   = pwdata[7:0];
  assign hit_src = aligned & (widx == IDX_SRC_SEL);
  assign hit_out = aligned & (widx == IDX_OUT_EN);

  // answer one cycle after the access phase opens
  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_go;
      pslverr <= acc_go & ~mapped;
      if (acc_go) begin
        prdata <= pwrite ? '0 : rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // shared configuration: source select and toggle enable
  // ----------------------------------------------------------------
  logic [7:0] src_sel;
  logic [1:0] out_en;

  // software writes, reset leaves system clock and toggles off
  always_ff @(posedge clk) begin
    if (reset) begin
      src_sel <= SRC_RST;
      out_en  <= OUT_EN_RST;
    end else begin
      if (wr_go & hit_src) begin
        src_sel <= wbyte;
      end
      if (wr_go & hit_out) begin
        out_en <= wbyte[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin samplers
  // ----------------------------------------------------------------
  logic [EVT_STAGES-1:0] evt_a_sh;
  logic [EVT_STAGES-1:0] evt_b_sh;
  logic [RTC_STAGES-1:0] rtc_sh;
  logic                  evt_a_rise;
  logic                  evt_b_rise;
  logic                  rtc_fall;

  // sampling chains on the synchronous pins
  always_ff @(posedge clk) begin
    if (reset) begin
      evt_a_sh <= '0;
      evt_b_sh <= '0;
      rtc_sh   <= '0;
    end else begin
      evt_a_sh <= {evt_a_sh[EVT_STAGES-2:0], event_pin_a};
      evt_b_sh <= {evt_b_sh[EVT_STAGES-2:0], event_pin_b};
      rtc_sh   <= {rtc_sh[0], rtc_osc_output};
    end
  end

  // rise seen late enough for update on fifth edge
  assign evt_a_rise = evt_a_sh[EVT_STAGES-2] & ~evt_a_sh[EVT_STAGES-1];
  assign evt_b_rise = evt_b_sh[EVT_STAGES-2] & ~evt_b_sh[EVT_STAGES-1];
  // fall seen after first edge, counter moves on second
  assign rtc_fall   = rtc_sh[1] & ~rtc_sh[0];

  // ----------------------------------------------------------------
  // timer instances
  // ----------------------------------------------------------------
  logic [31:0] rd_part   [NTMR];
  logic        hit_any   [NTMR];
  logic        eoc_v     [NTMR];
  logic [NTMR-1:0] next_irq;

  for (genvar t = 0; t < NTMR; t++) begin : g_tmr
    logic [15:0] cnt;
    logic [15:0] reload;
    logic [7:0]  hold;
    logic [7:0]  presc;
    logic        flag;
    rtarr_ctl_s  ctl;
    rtarr_ctl_s  next_ctl;
    logic [15:0] next_cnt;
    logic        next_flag;
    logic [1:0]  src;
    logic        evt_rise;
    logic        hit_ctl;
    logic        hit_low;
    logic        hit_high;
    logic        ctl_wr;
    logic        restart;
    logic        presc_tc;
    logic        tick;
    logic        step;
    logic        eoc;

    // source select exists only for timers 0..3
    if (t < NSRC_TMR) begin : g_src
      assign src = src_sel[2*t +: 2];
    end else begin : g_nosrc
      assign src = SRC_SYS;
    end
    // timers 0 and 2 on pin a, 1 and 3 on pin b
    assign evt_rise = (t % 2 == 0) ? evt_a_rise : evt_b_rise;

    // register decode
    assign hit_ctl  = aligned & (widx == tmr_idx(t, SUB_CTL));
    assign hit_low  = aligned & (widx == tmr_idx(t, SUB_LOW));
    assign hit_high = aligned & (widx == tmr_idx(t, SUB_HIGH));
    assign hit_any[t] = hit_ctl | hit_low | hit_high;
    assign ctl_wr   = wr_go & hit_ctl;
    assign restart  = ctl_wr & wbyte[CTL_RST_BIT];

    // tick selection: prescaler, rtc fall or pin rise
    assign presc_tc = (presc == PRESC_TOP[ctl.div]);
    assign tick = (src == SRC_RTC) ? rtc_fall :
                  (src == SRC_EVT) ? evt_rise : presc_tc;
    assign step = ctl.run & tick & ~restart;
    // end of count only on the step out of 0001h
    assign eoc  = step & (cnt == CNT_ONE);
    assign eoc_v[t] = eoc;

    // counter next value
    assign next_cnt = restart ? reload :
                      ~step   ? cnt :
                      ~eoc    ? cnt - 16'h0001 :
                      ctl.mode ? reload : CNT_ZERO;

    // control next value; single pass drops run at the end
    always_comb begin
      next_ctl = ctl;
      if (ctl_wr) begin
        next_ctl.run    = wbyte[CTL_RUN_BIT];
        next_ctl.rst_en = wbyte[CTL_RST_BIT];
        next_ctl.div    = wbyte[CTL_DIV_LSB +: 2];
        next_ctl.mode   = wbyte[CTL_MODE_BIT];
        next_ctl.ie     = wbyte[CTL_IE_BIT];
      end else if (eoc & ~ctl.mode) begin
        next_ctl.run = 1'b0;
      end
    end

    // flag: a new end of count beats the read clear
    assign next_flag = eoc ? 1'b1 : (rd_go & hit_ctl) ? 1'b0 : flag;
    assign next_irq[t] = next_flag & next_ctl.ie;

    // per-timer state, nothing shared with neighbours
    always_ff @(posedge clk) begin
      if (reset) begin
        cnt  <= CNT_RST;
        ctl  <= CTL_RST;
        flag <= 1'b0;
      end else begin
        cnt  <= next_cnt;
        ctl  <= next_ctl;
        flag <= next_flag;
      end
    end

    // reload value halves written at the data addresses
    always_ff @(posedge clk) begin
      if (reset) begin
        reload <= CNT_RST;
      end else begin
        if (wr_go & hit_low) begin
          reload[7:0] <= wbyte;
        end
        if (wr_go & hit_high) begin
          reload[15:8] <= wbyte;
        end
      end
    end

    // high byte held when the low byte is read
    always_ff @(posedge clk) begin
      if (reset) begin
        hold <= 8'h00;
      end else if (rd_go & hit_low) begin
        hold <= cnt[15:8];
      end
    end

    // prescaler runs only on the system clock source
    always_ff @(posedge clk) begin
      if (reset) begin
        presc <= 8'h00;
      end else if (restart | ~ctl.run | (src != SRC_SYS) | presc_tc) begin
        presc <= 8'h00;
      end else begin
        presc <= presc + 8'h01;
      end
    end

    // read view of this timer, reads leave the counter alone
    assign rd_part[t] = hit_ctl  ? {24'h0, flag, ctl.ie, 1'b0, ctl.mode,
                                    ctl.div, ctl.rst_en, ctl.run} :
                        hit_low  ? {24'h0, cnt[7:0]} :
                        hit_high ? {24'h0, hold} : 32'h0;
  end

  // ----------------------------------------------------------------
  // read mux and map check
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = hit_src ? {24'h0, src_sel} :
             hit_out ? {30'h0, out_en} : 32'h0;
    mapped = hit_src | hit_out;
    for (int i = 0; i < NTMR; i++) begin
      rd_mux = rd_mux | rd_part[i];
      mapped = mapped | hit_any[i];
    end
  end

  // ----------------------------------------------------------------
  // interrupt lines and toggle outputs
  // ----------------------------------------------------------------
  // one request line per timer
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_irq <= '0;
    end else begin
      timer_irq <= next_irq;
    end
  end

  // toggle on each end of count of timer 4 (pin a) and timer 5 (pin b), low while disabled
  always_ff @(posedge clk) begin
    if (reset) begin
      toggle_out_pin_a    <= 1'b0;
      toggle_out_pin_b    <= 1'b0;
      toggle_out_pin_a_oe <= 1'b0;
      toggle_out_pin_b_oe <= 1'b0;
    end else begin
      toggle_out_pin_a_oe <= out_en[0];
      toggle_out_pin_b_oe <= out_en[1];
      if (!out_en[0]) begin
        toggle_out_pin_a <= 1'b0;
      end else if (eoc_v[4]) begin
        toggle_out_pin_a <= ~toggle_out_pin_a;
      end
      if (!out_en[1]) begin
        toggle_out_pin_b <= 1'b0;
      end else if (eoc_v[5]) begin
        toggle_out_pin_b <= ~toggle_out_pin_b;
      end
    end
  end

endmodule

// >>> shared/rtarr_pkg.sv
// constants and types for the six-way reload timer array
package rtarr_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NTMR     = 6;
  localparam int NSRC_TMR = 4;
  localparam int AW       = 12;
  localparam int DW       = 32;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_TMR_BASE = 10'h080;
  localparam logic [9:0] IDX_STRIDE   = 10'h003;
  localparam logic [9:0] SUB_CTL      = 10'h000;
  localparam logic [9:0] SUB_LOW      = 10'h001;
  localparam logic [9:0] SUB_HIGH     = 10'h002;
  localparam logic [9:0] IDX_SRC_SEL  = 10'h098;
  localparam logic [9:0] IDX_OUT_EN   = 10'h099;

  // ----------------------------------------------------------------
  // control register field positions
  // ----------------------------------------------------------------
  localparam int CTL_RUN_BIT  = 0;
  localparam int CTL_RST_BIT  = 1;
  localparam int CTL_DIV_LSB  = 2;
  localparam int CTL_MODE_BIT = 4;
  localparam int CTL_IE_BIT   = 6;
  localparam int CTL_FLAG_BIT = 7;

  // ----------------------------------------------------------------
  // prescaler terminal counts for divide by 4, 16, 64, 256
  // ----------------------------------------------------------------
  localparam logic [3:0][7:0] PRESC_TOP = {8'hff, 8'h3f, 8'h0f, 8'h03};

  // ----------------------------------------------------------------
  // input source codes, two bits per timer 0..3
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_SYS = 2'h0;
  localparam logic [1:0] SRC_RTC = 2'h1;
  localparam logic [1:0] SRC_EVT = 2'h2;

  // ----------------------------------------------------------------
  // count values and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_ONE     = 16'h0001;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [7:0]  SRC_RST     = 8'h00;
  localparam logic [1:0]  OUT_EN_RST  = 2'h0;
  localparam int          EVT_STAGES  = 5;
  localparam int          RTC_STAGES  = 2;

  // ----------------------------------------------------------------
  // stored control fields of one timer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ie;
    logic       mode;
    logic [1:0] div;
    logic       rst_en;
    logic       run;
  } rtarr_ctl_s;

  localparam rtarr_ctl_s CTL_RST = '0;

endpackage

// >>> tb/rtarr_properties.sv
// port-level assertions for the reload timer array
module rtarr_properties
  import rtarr_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   reset,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [rtarr_pkg::AW-1:0] paddr,
  input wire logic [rtarr_pkg::DW-1:0] prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   rtc_osc_output,
  input wire logic                   event_pin_b,
  input wire logic [rtarr_pkg::NTMR-1:0] timer_irq,
  input wire logic                   toggle_out_pin_a,
  input wire logic                   toggle_out_pin_a_oe,
  input wire logic                   toggle_out_pin_b,
  input wire logic                   toggle_out_pin_b_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // helpers and checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // access cycle and timer 3 control select
  wire acc  = psel && penable && !pready;
  wire c3   = psel && paddr == 12'h224;
  // no toggle of pin b for three cycles
  sequence quiet_b;
    (!$changed(toggle_out_pin_b) || !toggle_out_pin_b_oe) [*3];
  endsequence
  wait_state_a: assert property (acc |=> pready)
    else $error("pready missing after access");
  refuse_a: assert property (acc && paddr == 12'h280 |=> pslverr)
    else $error("unmapped access not refused");
  rdata_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  irq_hold_a: assert property ($fell(timer_irq[3]) |-> $past(c3) || $past(c3, 2))
    else $error("request dropped without control access");
  reset_a: assert property (disable iff (1'b0) reset |=> timer_irq == '0
    && !toggle_out_pin_a_oe && !toggle_out_pin_b_oe) else $error("outputs active after reset");
  event_a: assert property ($rose(timer_irq[1])
    |-> $past(event_pin_b, 5) && !$past(event_pin_b, 6)) else $error("event delay wrong");
  rtc_a: assert property ($rose(timer_irq[2])
    |-> !$past(rtc_osc_output, 2) && $past(rtc_osc_output, 3)) else $error("rtc delay wrong");
  toggle_irq_a: assert property ($rose(timer_irq[4]) && $past(toggle_out_pin_a_oe)
    |-> $changed(toggle_out_pin_a)) else $error("toggle not at end of count");
  toggle_gap_a: assert property ($changed(toggle_out_pin_b) && toggle_out_pin_b_oe
    |=> quiet_b) else $error("toggle faster than four cycles");
  toggle_off_a: assert property (!toggle_out_pin_a_oe |-> !toggle_out_pin_a)
    else $error("disabled toggle pin not low");
endmodule

// >>> tb/rtarr_pins_model.sv
// pin-side model: event and rtc pulse source, toggle pin observer
module rtarr_pins_model (
  input  wire logic       clk,
  input  wire logic       fire_a,
  input  wire logic       fire_b,
  input  wire logic       fire_rtc,
  input  wire logic       toggle_pin,
  input  wire logic       toggle_oe,
  output logic            event_pin_a,
  output logic            event_pin_b,
  output logic            rtc_osc_output,
  output logic [7:0]      tog_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_a  = '0;
  logic [1:0] ph_b  = '0;
  logic [1:0] ph_r  = '0;
  logic       pin_q = 1'b0;
  logic [7:0] tog_q = '0;
  // next pulse phase: a request starts two cycles high then two low
  function automatic logic [1:0] ph_next(input logic fire, input logic [1:0] ph);
    if (fire && ph == 2'h0) return 2'h3;
    if (ph == 2'h0) return 2'h0;
    return ph - 2'h1;
  endfunction
  // pins driven only toward the device
  assign event_pin_a    = ph_a[1];
  assign event_pin_b    = ph_b[1];
  assign rtc_osc_output = !ph_r[1];
  assign tog_cnt        = tog_q;
  // pulse phase counters and toggle counting while the pin is handed over
  always_ff @(posedge clk) begin
    ph_a  <= ph_next(fire_a, ph_a);
    ph_b  <= ph_next(fire_b, ph_b);
    ph_r  <= ph_next(fire_rtc, ph_r);
    pin_q <= toggle_pin;
    if (toggle_oe && toggle_pin != pin_q) begin
      tog_q <= tog_q + 8'h01;
    end
  end
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the reload timer array
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rtarr_pkg::*;
  logic            clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic            fire_a = 0, fire_b = 0, fire_rtc = 0, pready, pslverr, rtc, evt_b, err;
  logic            evt_a;
  logic            tpa, tpa_oe, tpb, tpb_oe;
  logic [AW-1:0]   paddr = '0;
  logic [DW-1:0]   pwdata = '0, prdata;
  logic [NTMR-1:0] irq;
  logic [7:0]      tog_cnt, d, old;
  int              n_fail = 0, num_checks = 0, cyc;
  // ----------------------------------------------------------------
  // design, pin model, clock
  // ----------------------------------------------------------------
  rtarr_top i_rtarr_top (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rtc_osc_output(rtc), .event_pin_a(evt_a), .event_pin_b(evt_b),
    .timer_irq(irq), .toggle_out_pin_a(tpa), .toggle_out_pin_a_oe(tpa_oe),
    .toggle_out_pin_b(tpb), .toggle_out_pin_b_oe(tpb_oe));
  rtarr_pins_model i_rtarr_pins_model (.clk(clk), .fire_a(fire_a), .fire_b(fire_b),
    .fire_rtc(fire_rtc), .toggle_pin(tpa), .toggle_oe(tpa_oe), .event_pin_a(evt_a),
    .event_pin_b(evt_b), .rtc_osc_output(rtc), .tog_cnt(tog_cnt));
  initial forever #4 clk = ~clk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task finish_test;
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function logic [9:0] ix(int t, logic [9:0] s);
    return IDX_TMR_BASE + IDX_STRIDE * t[9:0] + s;
  endfunction
  // one apb transfer, held until pready is sampled high
  task xfer(input logic w, input logic [9:0] idx, input logic [7:0] wd);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    // values read right after the edge are the ones the edge sampled
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      finish_test();
    end
    d = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [9:0] idx, input logic [7:0] v); xfer(1'b1, idx, v); endtask
  task rd(input logic [9:0] idx); xfer(1'b0, idx, 8'h00); endtask
  // bounded waits: request of one timer, or a toggle seen by the pin model
  task wirq(input int t, input int mx);
    cyc = 0;
    do begin @(negedge clk); cyc++; end while (irq[t] !== 1'b1 && cyc < mx);
    if (irq[t] !== 1'b1) begin n_fail++; finish_test(); end
    @(posedge clk);
  endtask
  task wtog;
    old = tog_cnt;
    cyc = 0;
    do begin @(negedge clk); cyc++; end while (tog_cnt === old && cyc < 60);
    if (tog_cnt === old) begin n_fail++; finish_test(); end
    @(posedge clk);
  endtask
  task pulse(input logic a, input logic b, input logic r);
    fire_a <= a;
    fire_b <= b;
    fire_rtc <= r;
    @(posedge clk);
    fire_a <= 1'b0;
    fire_b <= 1'b0;
    fire_rtc <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rd(ix(0, SUB_CTL)); cmp("ctl0 reset", 16'h0, d);
    rd(ix(5, SUB_HIGH)); cmp("cnt5 high reset", 16'h0, d);
    rd(10'h0a0); cmp("unmapped err", 16'h1, err);
    wr(ix(3, SUB_LOW), 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(ix(3, SUB_CTL), 8'h43 | 8'(i << 2));
      wirq(3, 300); cmp("divider period", 16'(4 << (2 * i)), cyc[15:0]);
      rd(ix(3, SUB_CTL)); cmp("ctl3 single end", 8'hc2 | 8'(i << 2), d);
      cmp("irq3 cleared", 16'h0, irq[3]);
    end
    wr(ix(3, SUB_CTL), 8'h41);
    repeat (40) @(posedge clk);
    rd(ix(3, SUB_LOW));
    repeat (1100) @(posedge clk);
    rd(ix(3, SUB_HIGH)); cmp("latched high", 16'hff, d);
    rd(ix(3, SUB_LOW));
    rd(ix(3, SUB_HIGH)); cmp("live high", 16'hfe, d);
    cmp("no flag on wrap", 16'h0, irq[3]);
    wr(ix(3, SUB_CTL), 8'h40);
    rd(ix(3, SUB_LOW)); old = d;
    repeat (20) @(posedge clk);
    rd(ix(3, SUB_LOW)); cmp("held count", old, d);
    rd(ix(3, SUB_CTL)); cmp("ctl3 stopped", 16'h40, d);
    wr(IDX_OUT_EN, 8'h03);
    wr(ix(4, SUB_LOW), 8'h03);
    wr(ix(4, SUB_CTL), 8'h53);
    wr(ix(5, SUB_LOW), 8'h01);
    wr(ix(5, SUB_CTL), 8'h13);
    wtog(); wtog(); cmp("toggle gap", 16'd12, cyc[15:0]);
    rd(ix(4, SUB_CTL)); cmp("ctl4 running", 16'hd3, d);
    cmp("irq5 masked", 16'h0, irq[5]);
    wr(IDX_SRC_SEL, 8'h1a);
    wr(ix(0, SUB_LOW), 8'h01);
    wr(ix(0, SUB_CTL), 8'h53);
    wr(ix(1, SUB_LOW), 8'h03);
    wr(ix(1, SUB_CTL), 8'h53);
    wr(ix(2, SUB_LOW), 8'h02);
    wr(ix(2, SUB_CTL), 8'h43);
    repeat (2) pulse(1'b0, 1'b1, 1'b1);
    cmp("event early", 16'h0, irq[1]);
    cmp("pin a quiet", 16'h0, irq[0]);
    cmp("rtc count", 16'h1, irq[2]);
    pulse(1'b1, 1'b0, 1'b0); cmp("pin a event", 16'h1, irq[0]);
    cmp("pin b still", 16'h0, irq[1]);
    pulse(1'b0, 1'b1, 1'b0); cmp("event count", 16'h1, irq[1]);
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    cmp("oe after reset", 16'h0, {tpa_oe, tpb_oe});
    rd(ix(4, SUB_CTL)); cmp("ctl4 after reset", 16'h0, d);
    finish_test();
  end
  initial begin
    #800000;
    n_fail++;
    finish_test();
  end
endmodule
bind rtarr_top rtarr_properties i_rtarr_properties (.clk, .reset, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .rtc_osc_output, .event_pin_b, .timer_irq,
  .toggle_out_pin_a, .toggle_out_pin_a_oe, .toggle_out_pin_b, .toggle_out_pin_b_oe);
